// ===== hdl/pst_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module pst_status_regs (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Management link pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [6:0] i_dev_addr,
  // Sense inputs
  input wire logic i_ov_pin,
  input wire pst_pkg::pst_cond_t i_cond,
  input wire pst_pkg::pst_meas_t i_meas,
  input wire logic [9:0] i_oc_fault_limit,
  input wire logic [9:0] i_oc_warn_limit,
  // Status outputs
  output logic o_iout_oc_fault,
  output logic o_iout_oc_warn,
  output logic o_clear_faults
);
  import pst_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Sticky flag: set wins, clear only takes effect once the cause is gone
  function automatic logic latch_flag(input logic old, input logic cond, input logic clr);
    latch_flag = clr ? cond : (old | cond);
  endfunction

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == CMD_CLEAR_FAULTS) || (c == CMD_INPUT_FLAGS) || (c == CMD_TEMP_FLAGS) ||
                (c == CMD_COMM_FLAGS) || (c == CMD_VIN_READING) ||
                (c == CMD_VOUT_READING) || (c == CMD_IOUT_READING);
  endfunction

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] ovp_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Two flops before use, third stage only for edge finding
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      ovp_q <= 2'h0;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
      ovp_q <= {ovp_q[0], i_ov_pin};
    end
  end

  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_seen = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  pst_state_t state_q;
  logic [3:0] bit_q;
  logic [2:0] idx_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] tx_next;
  logic [7:0] cmd_q;
  logic is_read_q;
  logic match_q;
  logic mack_q;
  logic [15:0] word_q;
  logic clr_q;
  logic bad_cmd_ev;
  logic bad_data_ev;
  logic [7:0] in_flags_q;
  logic [7:0] temp_flags_q;
  logic [7:0] comm_flags_q;

  // Byte selected for the next transmit slot
  function automatic logic [7:0] tx_pick(input logic [7:0] c, input logic [2:0] i,
                                         input logic [15:0] w);
    logic status_cmd;
    status_cmd = (c == CMD_INPUT_FLAGS) || (c == CMD_TEMP_FLAGS) || (c == CMD_COMM_FLAGS);
    if (status_cmd) begin
      tx_pick = (i == IDX_ADDR) ? w[7:0] : FLAGS_RESET;
    end else if (i == IDX_ADDR) begin
      tx_pick = w[7:0];
    end else if (i == IDX_CMD) begin
      tx_pick = w[15:8];
    end else begin
      tx_pick = FLAGS_RESET;
    end
  endfunction

  // Snapshot of the addressed register, so both bytes come from one sample
  function automatic logic [15:0] reg_pick(input logic [7:0] c);
    case (c)
      CMD_INPUT_FLAGS: reg_pick = {8'h00, in_flags_q};
      CMD_TEMP_FLAGS: reg_pick = {8'h00, temp_flags_q};
      CMD_COMM_FLAGS: reg_pick = {8'h00, comm_flags_q};
      CMD_VIN_READING: reg_pick = {6'h00, i_meas.vin};
      CMD_VOUT_READING: reg_pick = {6'h00, i_meas.vout};
      CMD_IOUT_READING: reg_pick = {6'h00, i_meas.iout};
      default: reg_pick = 16'h0000;
    endcase
  endfunction

  assign bad_cmd_ev = (state_q == PST_RECV) && scl_fall && (bit_q == BIT_ACK) &&
                      (idx_q == IDX_CMD) && !known_cmd(rx_q);
  assign bad_data_ev = (state_q == PST_RECV) && scl_fall && (bit_q == BIT_ACK) &&
                       (idx_q >= IDX_DATA);

  // Next byte to send, picked by the current byte index
  assign tx_next = tx_pick(cmd_q, idx_q, word_q);

  // Transaction sequencer: receive bytes, acknowledge, send bytes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= PST_IDLE;
      bit_q <= BIT_ZERO;
      idx_q <= IDX_ADDR;
      rx_q <= FLAGS_RESET;
      tx_q <= FLAGS_RESET;
      cmd_q <= FLAGS_RESET;
      is_read_q <= 1'b0;
      match_q <= 1'b0;
      mack_q <= 1'b0;
      word_q <= 16'h0000;
      o_sda_oe <= 1'b0;
    end else if (start_seen) begin
      state_q <= PST_RECV;
      bit_q <= BIT_ZERO;
      idx_q <= IDX_ADDR;
      o_sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state_q <= PST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_q)
        PST_RECV: begin
          if (scl_rise && bit_q < BIT_ACK) begin
            rx_q <= {rx_q[6:0], sda_q[1]};
            bit_q <= bit_q + 4'h1;
          end else if (scl_rise && bit_q == BIT_ACK) begin
            bit_q <= BIT_DONE;
          end else if (scl_fall && bit_q == BIT_ACK) begin
            if (idx_q == IDX_ADDR) begin
              match_q <= (rx_q[7:1] == i_dev_addr);
              is_read_q <= rx_q[0];
              o_sda_oe <= (rx_q[7:1] == i_dev_addr);
            end else if (idx_q == IDX_CMD) begin
              cmd_q <= rx_q;
              word_q <= reg_pick(rx_q);
              o_sda_oe <= 1'b1;
            end else begin
              o_sda_oe <= 1'b0; // Nothing here is writable: refuse data
            end
          end else if (scl_fall && bit_q == BIT_DONE) begin
            o_sda_oe <= 1'b0;
            bit_q <= BIT_ZERO;
            if (!match_q || (idx_q >= IDX_DATA)) begin
              state_q <= PST_WAIT;
            end else if (idx_q == IDX_ADDR && is_read_q) begin
              state_q <= PST_SEND;
              tx_q <= tx_next;
              o_sda_oe <= ~tx_next[7];
              idx_q <= IDX_CMD;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
        end
        PST_SEND: begin
          if (scl_rise && bit_q < BIT_ACK) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_rise && bit_q == BIT_ACK) begin
            mack_q <= ~sda_q[1];
            bit_q <= BIT_DONE;
          end else if (scl_fall && bit_q < BIT_ACK) begin
            tx_q <= {tx_q[6:0], 1'b0};
            o_sda_oe <= ~tx_q[6];
          end else if (scl_fall && bit_q == BIT_ACK) begin
            o_sda_oe <= 1'b0; // Host drives its acknowledge
          end else if (scl_fall && bit_q == BIT_DONE) begin
            bit_q <= BIT_ZERO;
            if (mack_q) begin
              tx_q <= tx_next;
              o_sda_oe <= ~tx_next[7];
              if (idx_q != IDX_MAX) begin
                idx_q <= idx_q + 3'h1;
              end
            end else begin
              state_q <= PST_WAIT;
            end
          end
        end
        PST_WAIT: begin
          o_sda_oe <= 1'b0;
        end
        PST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        default: begin
          state_q <= PST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Clear-faults is a send-byte: address write plus command, then stop
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= stop_seen && (state_q == PST_RECV) && match_q && !is_read_q &&
               (idx_q == IDX_DATA) && (cmd_q == CMD_CLEAR_FAULTS);
    end
  end

  // ****************************************************************
  // Status registers
  // ****************************************************************
  // Input flags; reserved low bits stay zero
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_flags_q <= FLAGS_RESET;
    end else begin
      in_flags_q[IN_OV_FAULT_BIT] <= latch_flag(in_flags_q[IN_OV_FAULT_BIT], ovp_q[1],
                                                clr_q);
      in_flags_q[IN_OV_WARN_BIT] <= latch_flag(in_flags_q[IN_OV_WARN_BIT], i_cond.vin_ov_warn,
                                               clr_q);
      in_flags_q[IN_UV_WARN_BIT] <= latch_flag(in_flags_q[IN_UV_WARN_BIT], i_cond.vin_uv_warn,
                                               clr_q);
      in_flags_q[4:0] <= FLAGS_RESET[4:0];
    end
  end

  // Temperature flags
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_flags_q <= FLAGS_RESET;
    end else begin
      temp_flags_q[TEMP_FAULT_BIT] <= latch_flag(temp_flags_q[TEMP_FAULT_BIT], i_cond.ot_fault,
                                                 clr_q);
      temp_flags_q[TEMP_WARN_BIT] <= latch_flag(temp_flags_q[TEMP_WARN_BIT], i_cond.ot_warn,
                                                clr_q);
      temp_flags_q[5:0] <= FLAGS_RESET[5:0];
    end
  end

  // Communication and memory flags
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      comm_flags_q <= FLAGS_RESET;
    end else begin
      comm_flags_q <= FLAGS_RESET;
      comm_flags_q[COMM_BAD_CMD_BIT] <= latch_flag(comm_flags_q[COMM_BAD_CMD_BIT], bad_cmd_ev,
                                                   clr_q);
      comm_flags_q[COMM_BAD_DATA_BIT] <= latch_flag(comm_flags_q[COMM_BAD_DATA_BIT],
                                                    bad_data_ev, clr_q);
      comm_flags_q[COMM_MEM_FAULT_BIT] <= latch_flag(comm_flags_q[COMM_MEM_FAULT_BIT],
                                                     i_cond.mem_fault, clr_q);
      comm_flags_q[COMM_OTHER_BIT] <= latch_flag(comm_flags_q[COMM_OTHER_BIT],
                                                 i_cond.other_fault, clr_q);
      comm_flags_q[COMM_MEM_BUSY_BIT] <= latch_flag(comm_flags_q[COMM_MEM_BUSY_BIT],
                                                    i_cond.mem_busy, clr_q);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Current limit comparison, refreshed every cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_iout_oc_fault <= 1'b0;
      o_iout_oc_warn <= 1'b0;
    end else begin
      o_iout_oc_fault <= (i_meas.iout >= i_oc_fault_limit);
      o_iout_oc_warn <= (i_meas.iout >= i_oc_warn_limit);
    end
  end

  // Open-drain data only ever pulls low; clear pulse mirrors the flag clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda_out <= 1'b0;
      o_clear_faults <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_clear_faults <= clr_q;
    end
  end

endmodule // pst_status_regs

`default_nettype wire

// ===== shared/pst_pkg.sv
package pst_pkg;

  // ****************************************************************
  // Command codes on the management link
  // ****************************************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
  localparam logic [7:0] CMD_TEMP_FLAGS = 8'h7d;
  localparam logic [7:0] CMD_COMM_FLAGS = 8'h7e;
  localparam logic [7:0] CMD_VIN_READING = 8'h88;
  localparam logic [7:0] CMD_VOUT_READING = 8'h8b;
  localparam logic [7:0] CMD_IOUT_READING = 8'h8c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int IN_OV_FAULT_BIT = 7;
  localparam int IN_OV_WARN_BIT = 6;
  localparam int IN_UV_WARN_BIT = 5;
  localparam int TEMP_FAULT_BIT = 7;
  localparam int TEMP_WARN_BIT = 6;
  localparam int COMM_BAD_CMD_BIT = 7;
  localparam int COMM_BAD_DATA_BIT = 6;
  localparam int COMM_MEM_FAULT_BIT = 4;
  localparam int COMM_OTHER_BIT = 1;
  localparam int COMM_MEM_BUSY_BIT = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [9:0] READING_RESET = 10'h000;
  localparam int READING_W = 10;

  // ****************************************************************
  // Serial framing counts
  // ****************************************************************
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [2:0] IDX_ADDR = 3'h0;
  localparam logic [2:0] IDX_CMD = 3'h1;
  localparam logic [2:0] IDX_DATA = 3'h2;
  localparam logic [2:0] IDX_MAX = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    PST_IDLE = 4'b0001,
    PST_RECV = 4'b0010,
    PST_SEND = 4'b0100,
    PST_WAIT = 4'b1000
  } pst_state_t;

  typedef struct packed {
    logic [9:0] vin;
    logic [9:0] vout;
    logic [9:0] iout;
  } pst_meas_t;

  typedef struct packed {
    logic vin_ov_warn;
    logic vin_uv_warn;
    logic ot_fault;
    logic ot_warn;
    logic mem_fault;
    logic other_fault;
    logic mem_busy;
  } pst_cond_t;

endpackage

// ===== verification/pst_status_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker for the status and telemetry bank
// ****************************************************************
module pst_status_regs_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Link pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // Sense and status
  input wire pst_pkg::pst_meas_t i_meas,
  input wire logic [9:0] i_oc_fault_limit,
  input wire logic [9:0] i_oc_warn_limit,
  input wire logic o_iout_oc_fault,
  input wire logic o_iout_oc_warn,
  input wire logic o_clear_faults
);
  import pst_pkg::*;

  // One clock domain, reset masks every check
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_oc_fault;
    $past(i_rst_n) |-> o_iout_oc_fault == $past(i_meas.iout >= i_oc_fault_limit);
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("oc fault flag wrong");
  property p_warn_set;
    i_rst_n && (i_meas.iout >= i_oc_warn_limit) |=> o_iout_oc_warn;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("oc warn flag missing");
  property p_warn_clr;
    i_rst_n && (i_meas.iout < i_oc_warn_limit) |=> !o_iout_oc_warn;
  endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("oc warn flag stuck");
  property p_clr_pulse;
    o_clear_faults |=> !o_clear_faults;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
  property p_clr_after_stop;
    o_clear_faults |-> i_scl && i_sda && $past(i_sda, 4) && $past(i_scl, 4);
  endproperty
  a_clr_after_stop: assert property (p_clr_after_stop) else $error("clear not after stop");
  property p_sda_open_drain;
    !o_sda_out;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain) else $error("data pin driven high");
  property p_oe_scl_low;
    $rose(o_sda_oe) |-> !i_scl && !$past(i_scl);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("drive starts in clock high");
  property p_oe_hold;
    $rose(o_sda_oe) |-> o_sda_oe [*6];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive dropped early");
endmodule // pst_status_regs_checker

bind pst_status_regs pst_status_regs_checker chk_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_meas(i_meas),
  .i_oc_fault_limit(i_oc_fault_limit), .i_oc_warn_limit(i_oc_warn_limit),
  .o_iout_oc_fault(o_iout_oc_fault), .o_iout_oc_warn(o_iout_oc_warn),
  .o_clear_faults(o_clear_faults)
);

`default_nettype wire

// ===== verification/pst_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host controller on the management link
// ****************************************************************
module pst_host_model (
  // Clock
  input wire logic i_core_clk,
  // Link pins
  input wire logic i_sda_wire,
  output var logic o_scl,
  output var logic o_sda
);
  logic ok_q;

  // Idle link: clock stands high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // Start (a=1) or stop (a=0); low phase stretched to keep data clear of edges
  task automatic edge_c(input logic a);
    o_sda <= a;
    cyc(3);
    o_scl <= 1'b1;
    cyc(3);
    o_sda <= !a;
    cyc(3);
    if (a) o_scl <= 1'b0;
    if (a) cyc(3);
  endtask

  // One bit in 8 core cycles: data set mid low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    o_sda <= b;
    cyc(2);
    o_scl <= 1'b1;
    cyc(2);
    r = i_sda_wire;
    cyc(2);
    o_scl <= 1'b0;
    cyc(2);
  endtask

  // Byte out MSB first, acknowledge slot driven with k; w checks the device's acknowledge
  task automatic xbyte(input logic [7:0] v, input logic k, input logic w,
                       output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r[i]);
    bit_x(k, a);
    if (w) ok_q = ok_q & !a;
  endtask

  // Command write, optional data byte, optional read of nr bytes low first
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic wd,
                      input int nr, output logic [15:0] d, output logic ok);
    logic [7:0] r;
    ok_q = 1'b1;
    d = 16'h0000;
    edge_c(1'b1);
    xbyte({a, 1'b0}, 1'b1, 1'b1, r);
    xbyte(c, 1'b1, 1'b1, r);
    if (wd) xbyte(8'h5a, 1'b1, 1'b1, r);
    if (nr > 0) edge_c(1'b1);
    if (nr > 0) xbyte({a, 1'b1}, 1'b1, 1'b1, r);
    for (int i = 0; i < nr; i++) xbyte(8'hff, i == nr - 1, 1'b0, d[i*8 +: 8]);
    edge_c(1'b0);
    ok = ok_q;
  endtask
endmodule // pst_host_model

`default_nettype wire

// ===== verification/pst_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Testbench for the status and telemetry bank
// ****************************************************************
module pst_status_regs_tb_top;
  import pst_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ov_pin = 1'b0;
  logic scl, host_sda, sda_oe, oc_fault, oc_warn, ok, sda_out, clr_pulse;
  logic [9:0] fault_lim = 10'h200;
  logic [9:0] warn_lim = 10'h180;
  int clr_count = 0;
  logic [15:0] d;
  pst_cond_t cond = '0;
  pst_meas_t meas = {10'h3a5, 10'h15a, 10'h3ff};
  logic [9:0] iout_vals [4] = '{10'h17f, 10'h180, 10'h1ff, 10'h200};
  int mismatches = 0;
  int num_checks = 0;
  wire logic sda_wire = host_sda & ~sda_oe;

  // 20 MHz core clock
  initial forever #25 i_core_clk = ~i_core_clk;

  pst_status_regs dut_u (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_dev_addr(DEV_ADDR), .i_ov_pin(ov_pin),
    .i_cond(cond), .i_meas(meas), .i_oc_fault_limit(fault_lim), .i_oc_warn_limit(warn_lim),
    .o_iout_oc_fault(oc_fault), .o_iout_oc_warn(oc_warn), .o_clear_faults(clr_pulse)
  );

  // Count clear-faults pulses seen on the output
  always @(posedge i_core_clk) begin
    if (clr_pulse === 1'b1) clr_count <= clr_count + 1;
  end
  pst_host_model host_u (.i_core_clk(i_core_clk), .i_sda_wire(sda_wire), .o_scl(scl),
    .o_sda(host_sda));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read n bytes of one command and compare
  task automatic rx(input logic [7:0] c, input int n, input logic [15:0] e);
    host_u.xfer(DEV_ADDR, c, 1'b0, n, d, ok);
    chk(d, e);
    chk({15'h0000, ok}, 16'h0001);
  endtask

  // Clear faults and expect exactly one pulse on the clear output
  task automatic clear_all();
    int n0;
    n0 = clr_count;
    host_u.xfer(DEV_ADDR, CMD_CLEAR_FAULTS, 1'b0, 0, d, ok);
    host_u.cyc(4);
    chk({15'h0000, ok}, 16'h0001);
    chk(16'(clr_count - n0), 16'h0001);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cut a hung run short
  initial begin
    repeat (40000) @(posedge i_core_clk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    host_u.cyc(4);
    i_rst_n <= 1'b1;
    host_u.cyc(4);
    for (int i = 0; i < 3; i++) rx(CMD_INPUT_FLAGS + 8'(i), 1, 16'h0000);
    rx(CMD_VIN_READING, 2, 16'h03a5);
    rx(CMD_VOUT_READING, 2, 16'h015a);
    rx(CMD_IOUT_READING, 2, 16'h03ff);
    for (int i = 0; i < 4; i++) begin
      meas.iout <= iout_vals[i];
      host_u.cyc(3);
      chk({14'h0000, oc_fault, oc_warn}, {14'h0000, i == 3, i > 0});
    end
    // Move both limits: fault out of reach, warning exactly at the reading
    fault_lim <= 10'h3ff;
    warn_lim <= 10'h200;
    host_u.cyc(3);
    chk({14'h0000, oc_fault, oc_warn}, 16'h0001);
    ov_pin <= 1'b1;
    cond <= '1;
    host_u.cyc(4);
    cond <= 7'h08;
    host_u.cyc(4);
    rx(CMD_INPUT_FLAGS, 1, 16'h00e0);
    rx(CMD_TEMP_FLAGS, 2, 16'h00c0);
    rx(CMD_COMM_FLAGS, 1, 16'h0013);
    rx(8'h55, 1, 16'h0000);
    host_u.xfer(DEV_ADDR, CMD_VIN_READING, 1'b1, 0, d, ok);
    chk({15'h0000, ok}, 16'h0000);
    rx(CMD_COMM_FLAGS, 1, 16'h00d3);
    // Clear while overvoltage and temperature warning persist
    clear_all();
    rx(CMD_INPUT_FLAGS, 1, 16'h0080);
    rx(CMD_TEMP_FLAGS, 1, 16'h0040);
    rx(CMD_COMM_FLAGS, 1, 16'h0000);
    ov_pin <= 1'b0;
    cond <= '0;
    host_u.cyc(4);
    clear_all();
    rx(CMD_INPUT_FLAGS, 1, 16'h0000);
    rx(CMD_TEMP_FLAGS, 1, 16'h0000);
    // A frame for another address draws no acknowledge
    host_u.xfer(DEV_ADDR ^ 7'h01, CMD_INPUT_FLAGS, 1'b0, 1, d, ok);
    chk({15'h0000, ok}, 16'h0000);
    chk({15'h0000, sda_out}, 16'h0000);
    report_and_stop();
  end
endmodule // pst_status_regs_tb_top

`default_nettype wire
